// ---- inc/afmx_pkg.sv ----
// constants for the output format, lane remap and pattern block
package afmx_pkg;
	// register addresses on the serial programming port
	localparam logic [11:0] AFMX_ADDR_PDN = 12'h101;
	localparam logic [11:0] AFMX_ADDR_LANE_CTRL = 12'h116;
	localparam logic [11:0] AFMX_ADDR_LANE_SEL0 = 12'h117;
	localparam logic [11:0] AFMX_ADDR_LANE_SEL7 = 12'h11e;
	localparam logic [11:0] AFMX_ADDR_PIN_FUNC = 12'h146;
	localparam logic [11:0] AFMX_ADDR_PAT_CTRL = 12'h14a;
	localparam logic [11:0] AFMX_ADDR_PAT_STEP = 12'h14b;
	localparam logic [11:0] AFMX_ADDR_FMT = 12'h162;
	localparam logic [11:0] AFMX_ADDR_DDC0_SEL = 12'h163;
	localparam logic [11:0] AFMX_ADDR_LAT_CTRL = 12'h165;
	localparam logic [11:0] AFMX_ADDR_DDC_COUNT = 12'h169;
	// reset value of every register
	localparam logic [7:0] AFMX_REG_RESET = 8'h00;
	// field positions
	localparam int AFMX_PDN_BIT = 4;
	localparam int AFMX_MUX_EN_BIT = 7;
	localparam int AFMX_FMT_OFFSET_BIT = 0;
	localparam int AFMX_FMT_WIDE_BIT = 1;
	localparam int AFMX_PAT_CLK_BIT = 4;
	localparam int AFMX_FAST_BIT = 4;
	// field codes
	localparam logic [3:0] AFMX_PAT_OFF = 4'h0;
	localparam logic [3:0] AFMX_PAT_TOGGLE = 4'h1;
	localparam logic [3:0] AFMX_PAT_RAMP = 4'h2;
	localparam logic [4:0] AFMX_PIN_PDN_AUX1 = 5'h03;
	localparam logic [4:0] AFMX_PIN_PDN_AUX0_A = 5'h0a;
	localparam logic [4:0] AFMX_PIN_PDN_AUX0_B = 5'h0b;
	localparam logic [7:0] AFMX_DDC0_AVG = 8'h02;
	// timing counts
	localparam int AFMX_LOW_LAT_CYCLES = 9;
	localparam logic [4:0] AFMX_SPI_LAST_ADDR = 5'h0f;
	localparam logic [4:0] AFMX_SPI_LAST_DATA = 5'h17;
	localparam logic [4:0] AFMX_SPI_FRAME = 5'h18;
endpackage

// ---- verilog/afmx_top.sv ----
// sample formatting, pattern generator, fifo and output lane remap
`timescale 1ns/1ps

module afmx_fifo #(
	parameter int WIDTH = 65,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_wr;
	logic do_rd;

	assign in_ready_o = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign do_wr = in_valid_i && in_ready_o;
	assign do_rd = out_valid_o && out_ready_i;

	always_ff @(posedge core_clk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd && !do_wr) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module afmx_top import afmx_pkg::*; #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic spi_sen_n_i,
	input wire logic spi_sclk_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	input wire logic aux_pin_0_i,
	input wire logic aux_pin_1_i,
	input wire logic clock_present_i,
	input wire logic [15:0] channel_a_sample_i,
	input wire logic [15:0] channel_b_sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	input wire logic [31:0] dec_a_i,
	input wire logic [31:0] dec_b_i,
	input wire logic dec_valid_i,
	output logic [15:0] output_lane_rise_o,
	output logic [15:0] output_lane_fall_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic power_down_o
);
	localparam int LL_STAGES = AFMX_LOW_LAT_CYCLES - 1;
	if (FIFO_DEPTH < 2) begin : g_bad_param
		$error("fifo depth too small");
	end

	////////////////////////////////////////////////////////////////////////////
	// synchronisers for pins that are not on the core clock
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic sclk_d;
	logic sclk_s, sen_n_s, sdio_s, aux0_s, aux1_s, clk_present_s;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sync1 <= 6'h3f;
			sync2 <= 6'h3f;
			sclk_d <= 1'b1;
		end else begin
			sync1 <= {spi_sclk_i, spi_sen_n_i, sdio_i, aux_pin_0_i, aux_pin_1_i,
				clock_present_i};
			sync2 <= sync1;
			sclk_d <= sync2[5];
		end
	end
	assign {sclk_s, sen_n_s, sdio_s, aux0_s, aux1_s, clk_present_s} = sync2;

	////////////////////////////////////////////////////////////////////////////
	// serial programming port: 16 address bits then 8 data bits, msb first
	logic sclk_rise;
	logic sclk_fall;
	logic [4:0] bit_cnt;
	logic [15:0] addr_sh;
	logic [7:0] data_sh;
	logic [7:0] rd_sh;
	logic reading;
	logic wr_stb;
	logic [11:0] wr_addr;
	logic [7:0] wr_data;
	logic [11:0] rd_addr;
	logic [7:0] rd_val;

	assign sclk_rise = sclk_s && !sclk_d;
	assign sclk_fall = !sclk_s && sclk_d;
	assign wr_stb = !sen_n_s && sclk_rise && bit_cnt == AFMX_SPI_LAST_DATA && !reading
		&& addr_sh[15:12] == 4'h0;
	assign wr_addr = addr_sh[11:0];
	assign wr_data = {data_sh[6:0], sdio_s};
	assign rd_addr = {addr_sh[10:0], sdio_s};

	always_ff @(posedge core_clk_i) begin
		if (rst_i || sen_n_s) begin
			bit_cnt <= 5'h00;
			reading <= 1'b0;
			sdio_oe_o <= 1'b0;
			sdio_o <= 1'b0;
			addr_sh <= 16'h0000;
			data_sh <= 8'h00;
			rd_sh <= 8'h00;
		end else if (sclk_rise && bit_cnt != AFMX_SPI_FRAME) begin
			bit_cnt <= bit_cnt + 5'h01;
			if (bit_cnt <= AFMX_SPI_LAST_ADDR) begin
				addr_sh <= {addr_sh[14:0], sdio_s};
			end else begin
				data_sh <= wr_data;
			end
			// a read also blocks the write at the end of the frame
			if (bit_cnt == AFMX_SPI_LAST_ADDR) begin
				reading <= addr_sh[14] && addr_sh[13:11] == 3'h0;
				rd_sh <= rd_val;
			end
		end else if (sclk_fall && reading) begin
			sdio_o <= rd_sh[7];
			sdio_oe_o <= 1'b1;
			rd_sh <= {rd_sh[6:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] lane_ctrl, pin_func, pat_ctrl, pat_step, fmt, ddc0_sel, lat_ctrl;
	logic [7:0] ddc_count, pdn_ctrl;
	logic [7:0] lane_sel [8];
	logic [11:0] sel_off;

	assign sel_off = wr_addr - AFMX_ADDR_LANE_SEL0;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lane_ctrl <= AFMX_REG_RESET;
			pin_func <= AFMX_REG_RESET;
			pat_ctrl <= AFMX_REG_RESET;
			pat_step <= AFMX_REG_RESET;
			fmt <= AFMX_REG_RESET;
			ddc0_sel <= AFMX_REG_RESET;
			lat_ctrl <= AFMX_REG_RESET;
			ddc_count <= AFMX_REG_RESET;
			pdn_ctrl <= AFMX_REG_RESET;
			for (int i = 0; i < 8; i++) begin
				lane_sel[i] <= AFMX_REG_RESET;
			end
		end else if (wr_stb) begin
			case (wr_addr)
				AFMX_ADDR_LANE_CTRL: lane_ctrl <= wr_data;
				AFMX_ADDR_PIN_FUNC: pin_func <= wr_data;
				AFMX_ADDR_PAT_CTRL: pat_ctrl <= wr_data;
				AFMX_ADDR_PAT_STEP: pat_step <= wr_data;
				AFMX_ADDR_FMT: fmt <= wr_data;
				AFMX_ADDR_DDC0_SEL: ddc0_sel <= wr_data;
				AFMX_ADDR_LAT_CTRL: lat_ctrl <= wr_data;
				AFMX_ADDR_DDC_COUNT: ddc_count <= wr_data;
				AFMX_ADDR_PDN: pdn_ctrl <= wr_data;
				default: begin
					if (wr_addr >= AFMX_ADDR_LANE_SEL0 && wr_addr <= AFMX_ADDR_LANE_SEL7) begin
						lane_sel[sel_off[2:0]] <= wr_data;
					end
				end
			endcase
		end
	end

	always_comb begin
		rd_val = 8'h00;
		case (rd_addr)
			AFMX_ADDR_LANE_CTRL: rd_val = lane_ctrl;
			AFMX_ADDR_PIN_FUNC: rd_val = pin_func;
			AFMX_ADDR_PAT_CTRL: rd_val = pat_ctrl;
			AFMX_ADDR_PAT_STEP: rd_val = pat_step;
			AFMX_ADDR_FMT: rd_val = fmt;
			AFMX_ADDR_DDC0_SEL: rd_val = ddc0_sel;
			AFMX_ADDR_LAT_CTRL: rd_val = lat_ctrl;
			AFMX_ADDR_DDC_COUNT: rd_val = ddc_count;
			AFMX_ADDR_PDN: rd_val = pdn_ctrl;
			default: begin
				if (rd_addr >= AFMX_ADDR_LANE_SEL0 && rd_addr <= AFMX_ADDR_LANE_SEL7) begin
					rd_val = lane_sel[3'(rd_addr - AFMX_ADDR_LANE_SEL0)];
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// global power down
	logic pdn_req;

	assign pdn_req = pdn_ctrl[AFMX_PDN_BIT]
		|| (pin_func[4:0] == AFMX_PIN_PDN_AUX1 && aux1_s)
		|| ((pin_func[4:0] == AFMX_PIN_PDN_AUX0_A || pin_func[4:0] == AFMX_PIN_PDN_AUX0_B)
		&& aux0_s);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			power_down_o <= 1'b0;
		end else if (clk_present_s) begin
			power_down_o <= pdn_req;
		end
	end

	chk_pdn_clock: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!clk_present_s |=> $stable(power_down_o))
		else $error("power down changed without sampling clock");
	chk_pdn_aux1: assert property (@(posedge core_clk_i) disable iff (rst_i)
		clk_present_s && pin_func[4:0] == AFMX_PIN_PDN_AUX1 && aux1_s |=> power_down_o)
		else $error("aux pin 1 power down missed");

	////////////////////////////////////////////////////////////////////////////
	// source selection, averaging and test pattern
	logic fast_en, dec_mode, pat_on, pat_tick, src_valid, push, fifo_in_ready;
	logic [3:0] pat_type;
	logic [19:0] pattern;
	logic [16:0] avg_sum;
	logic [15:0] src_a16;
	logic [31:0] pre_a, pre_b, push_a, push_b;

	assign fast_en = lat_ctrl[AFMX_FAST_BIT];
	assign dec_mode = ddc_count[3:0] != 4'h0;
	assign pat_type = pat_ctrl[3:0];
	assign pat_on = pat_type != AFMX_PAT_OFF && !fast_en;
	// only the pattern clock choice matters in decimation; bypass ticks per sample
	assign pat_tick = dec_mode ? (pat_ctrl[AFMX_PAT_CLK_BIT] || dec_valid_i)
		: sample_valid_i;
	assign avg_sum = {channel_a_sample_i[15], channel_a_sample_i}
		+ {channel_b_sample_i[15], channel_b_sample_i};
	assign src_a16 = ddc0_sel == AFMX_DDC0_AVG ? avg_sum[16:1] : channel_a_sample_i;
	assign src_valid = dec_mode ? dec_valid_i : sample_valid_i;
	assign push = src_valid && !fast_en;

	always_ff @(posedge core_clk_i) begin
		if (rst_i || !pat_on) begin
			pattern <= 20'h00000;
		end else if (pat_tick) begin
			case (pat_type)
				AFMX_PAT_RAMP: pattern <= pattern + {12'h000, pat_step};
				AFMX_PAT_TOGGLE: pattern <= ~pattern;
				default: pattern <= pattern;
			endcase
		end
	end

	always_comb begin
		if (pat_on) begin
			pre_a = {pattern, 12'h000};
			pre_b = {pattern, 12'h000};
		end else if (dec_mode) begin
			pre_a = dec_a_i;
			pre_b = dec_b_i;
		end else begin
			pre_a = {src_a16, 16'h0000};
			pre_b = {channel_b_sample_i, 16'h0000};
		end
		// narrow samples keep the top half; msb sits at bit 31 for both widths
		push_a = fmt[AFMX_FMT_WIDE_BIT] ? pre_a : {pre_a[31:16], 16'h0000};
		push_b = fmt[AFMX_FMT_WIDE_BIT] ? pre_b : {pre_b[31:16], 16'h0000};
		push_a[31] = push_a[31] ^ fmt[AFMX_FMT_OFFSET_BIT];
		push_b[31] = push_b[31] ^ fmt[AFMX_FMT_OFFSET_BIT];
	end

	assign sample_ready_o = fast_en || fifo_in_ready;

	chk_ramp_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pat_on && pat_type == AFMX_PAT_RAMP && pat_tick
		|=> pattern == 20'($past(pattern) + {12'h000, $past(pat_step)}))
		else $error("ramp did not advance by step");
	chk_pattern_all: assert property (@(posedge core_clk_i) disable iff (rst_i)
		push && pat_on |-> push_a == push_b && push_a[30:16] == pattern[18:4])
		else $error("pattern differs between channels");
	chk_offset_msb: assert property (@(posedge core_clk_i) disable iff (rst_i)
		push && fmt[AFMX_FMT_OFFSET_BIT] |-> push_a[31] != pre_a[31]
		&& push_a[30:16] == pre_a[30:16])
		else $error("offset binary must flip only the msb");
	chk_width_16: assert property (@(posedge core_clk_i) disable iff (rst_i)
		push && !fmt[AFMX_FMT_WIDE_BIT] |-> push_a[15:0] == 16'h0000 && push_b[15:0] == 16'h0000)
		else $error("16-bit sample carries low half");

	////////////////////////////////////////////////////////////////////////////
	// sample fifo and low latency pipeline
	logic fifo_valid, fifo_pop, advance, lo_pending;
	logic [64:0] fifo_rd;
	logic [15:0] ll_a [LL_STAGES];
	logic [15:0] ll_b [LL_STAGES];
	logic [LL_STAGES-1:0] ll_v;
	logic [15:0] hold_lo_a, hold_lo_b, next_rise_raw, next_fall_raw, rise_map, fall_map;

	afmx_fifo #(
		.WIDTH(65),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i({fmt[AFMX_FMT_WIDE_BIT], push_a, push_b}),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_rd)
	);

	// the bypass ignores back-pressure: it cannot stall without breaking its latency
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ll_v <= '0;
			for (int i = 0; i < LL_STAGES; i++) begin
				ll_a[i] <= 16'h0000;
				ll_b[i] <= 16'h0000;
			end
		end else begin
			ll_v <= {ll_v[LL_STAGES-2:0], sample_valid_i && fast_en};
			ll_a[0] <= channel_a_sample_i;
			ll_b[0] <= channel_b_sample_i;
			for (int i = 1; i < LL_STAGES; i++) begin
				ll_a[i] <= ll_a[i-1];
				ll_b[i] <= ll_b[i-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output stage: a wide sample leaves as two beats, top halves first
	assign advance = !out_valid_o || out_ready_i;
	assign fifo_pop = !fast_en && advance && !lo_pending;

	always_comb begin
		next_rise_raw = hold_lo_a;
		next_fall_raw = hold_lo_b;
		if (fast_en) begin
			next_rise_raw = ll_a[LL_STAGES-1];
			next_fall_raw = ll_b[LL_STAGES-1];
		end else if (!lo_pending) begin
			next_rise_raw = fifo_rd[63:48];
			next_fall_raw = fifo_rd[31:16];
		end
	end

	for (genvar k = 0; k < 16; k++) begin : g_lane
		logic [3:0] src_idx;
		assign src_idx = lane_sel[k/2][(k%2)*4 +: 4];
		// several lanes may name the same source, giving duplicates
		assign rise_map[k] = lane_ctrl[AFMX_MUX_EN_BIT] ? next_rise_raw[src_idx]
			: next_rise_raw[k];
		assign fall_map[k] = lane_ctrl[AFMX_MUX_EN_BIT] ? next_fall_raw[src_idx]
			: next_fall_raw[k];
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			out_valid_o <= 1'b0;
			output_lane_rise_o <= 16'h0000;
			output_lane_fall_o <= 16'h0000;
			lo_pending <= 1'b0;
			hold_lo_a <= 16'h0000;
			hold_lo_b <= 16'h0000;
		end else if (fast_en) begin
			out_valid_o <= ll_v[LL_STAGES-1];
			output_lane_rise_o <= rise_map;
			output_lane_fall_o <= fall_map;
			lo_pending <= 1'b0;
		end else if (advance) begin
			if (lo_pending || fifo_valid) begin
				out_valid_o <= 1'b1;
				output_lane_rise_o <= rise_map;
				output_lane_fall_o <= fall_map;
			end else begin
				out_valid_o <= 1'b0;
			end
			if (lo_pending) begin
				lo_pending <= 1'b0;
			end else if (fifo_valid) begin
				lo_pending <= fifo_rd[64];
				hold_lo_a <= fifo_rd[47:32];
				hold_lo_b <= fifo_rd[15:0];
			end
		end
	end

	chk_low_latency_delay: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(fast_en && sample_valid_i) ##1 fast_en [*8] |=> out_valid_o)
		else $error("low latency sample not out after nine cycles");
	chk_pattern_blocked: assert property (@(posedge core_clk_i) disable iff (rst_i)
		fast_en && !lane_ctrl[AFMX_MUX_EN_BIT] |=> output_lane_rise_o == $past(ll_a[LL_STAGES-1])
		&& output_lane_fall_o == $past(ll_b[LL_STAGES-1]))
		else $error("pattern reached the lanes in low latency");
	chk_remap_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!fast_en && advance && !lo_pending && fifo_valid && !lane_ctrl[AFMX_MUX_EN_BIT]
		|=> output_lane_rise_o == $past(fifo_rd[63:48]) && out_valid_o)
		else $error("lanes remapped while remap disabled");
	chk_remap_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!fast_en && advance && !lo_pending && fifo_valid && lane_ctrl[AFMX_MUX_EN_BIT]
		|=> output_lane_rise_o[0] == $past(fifo_rd[48 + lane_sel[0][3:0]]))
		else $error("lane 0 does not carry its selected source");
	chk_fmt_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_stb && wr_addr == AFMX_ADDR_FMT |=> fmt == $past(wr_data))
		else $error("format register write lost");
endmodule

// ---- bench/afmx_rx_model.sv ----
// receiving side model: takes lane beats, can stall at random
`timescale 1ns/1ps
module afmx_rx_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic valid_i,
	input wire logic [15:0] rise_i,
	input wire logic [15:0] fall_i,
	output logic ready_o,
	output logic got_o,
	output logic [31:0] beat_o
);
	// a slow receiver accepts one cycle in four, enough to back the fifo up
	always_ff @(posedge core_clk_i) begin
		ready_o <= !rst_i && (!slow_i || ($urandom % 4 == 0));
	end
	always_ff @(posedge core_clk_i) begin
		got_o <= !rst_i && valid_i && ready_o;
		beat_o <= {rise_i, fall_i};
	end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the format, pattern and lane remap block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import afmx_pkg::*;
	logic clk = 1'b0, rst = 1'b1, sen_n = 1'b1, sclk = 1'b1, sdi = 1'b0;
	logic aux0 = 1'b0, aux1 = 1'b0, cp = 1'b1, sv = 1'b0, dv = 1'b0, slow = 1'b0;
	logic [15:0] channel_a_sample = 16'h0, channel_b_sample = 16'h0;
	logic [31:0] da = 32'h0, db = 32'h0;
	logic sdo, sdo_oe, srdy, ovld, ordy, pd, got;
	logic [15:0] rise, fall;
	logic [31:0] beat;
	logic [31:0] rx_q[$], exp_q[$];
	logic [7:0] rd;
	logic [7:0] sel [8];
	int n_fail = 0;
	int n_compared = 0;
	bit saw_full;
	logic rd_oe;
	logic [11:0] adr [10] = '{AFMX_ADDR_LANE_CTRL, AFMX_ADDR_LANE_SEL0, AFMX_ADDR_PIN_FUNC,
		AFMX_ADDR_PAT_CTRL, AFMX_ADDR_PAT_STEP, AFMX_ADDR_FMT, AFMX_ADDR_DDC0_SEL,
		AFMX_ADDR_LAT_CTRL, AFMX_ADDR_DDC_COUNT, 12'h300};
	logic [31:0] corner [3] = '{32'h7fffffff, 32'h0, 32'h80000000};
	logic [4:0] codes [3] = '{AFMX_PIN_PDN_AUX1, AFMX_PIN_PDN_AUX0_A, AFMX_PIN_PDN_AUX0_B};

	afmx_top #(.FIFO_DEPTH(16)) DUT (
		.core_clk_i(clk), .rst_i(rst), .spi_sen_n_i(sen_n), .spi_sclk_i(sclk),
		.sdio_i(sdi), .sdio_o(sdo), .sdio_oe_o(sdo_oe), .aux_pin_0_i(aux0),
		.aux_pin_1_i(aux1), .clock_present_i(cp), .channel_a_sample_i(channel_a_sample),
		.channel_b_sample_i(channel_b_sample), .sample_valid_i(sv), .sample_ready_o(srdy),
		.dec_a_i(da), .dec_b_i(db), .dec_valid_i(dv), .output_lane_rise_o(rise),
		.output_lane_fall_o(fall), .out_valid_o(ovld), .out_ready_i(ordy),
		.power_down_o(pd)
	);
	afmx_rx_model RX (
		.core_clk_i(clk), .rst_i(rst), .slow_i(slow), .valid_i(ovld), .rise_i(rise),
		.fall_i(fall), .ready_o(ordy), .got_o(got), .beat_o(beat)
	);

	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (got)
			rx_q.push_back(beat);
	end
	always @(negedge clk) begin
		if (srdy === 1'b0)
			saw_full = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// sclk half period is four core cycles; read bits are taken late in
	// the high phase, well before the next falling edge moves them
	task automatic spi(input logic r, input logic [11:0] a, input logic [7:0] d);
		logic [23:0] f;
		f = {r, 3'h0, a, d};
		sen_n <= 1'b0;
		cyc(4);
		for (int i = 23; i >= 0; i--) begin
			sclk <= 1'b0;
			sdi <= f[i];
			cyc(4);
			sclk <= 1'b1;
			cyc(4);
			if (i < 8)
				rd[i] = sdo;
			if (i == 0)
				rd_oe = sdo_oe;
		end
		sen_n <= 1'b1;
		cyc(5);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		spi(1'b0, a, d);
	endtask
	task automatic push(input logic dec, input logic [31:0] a, input logic [31:0] b);
		bit ok;
		da <= a;
		db <= b;
		channel_a_sample <= a[31:16];
		channel_b_sample <= b[31:16];
		dv <= dec;
		sv <= !dec;
		do begin
			@(negedge clk);
			ok = (srdy === 1'b1);
			@(posedge clk);
		end while (!ok);
	endtask
	task automatic idle();
		sv <= 1'b0;
		dv <= 1'b0;
	endtask
	function automatic void expect_fmt(logic [31:0] a, logic [31:0] b, bit w, bit o);
		logic [31:0] m;
		m = o ? 32'h80000000 : 32'h0;
		a = a ^ m;
		b = b ^ m;
		exp_q.push_back({a[31:16], b[31:16]});
		if (w)
			exp_q.push_back({a[15:0], b[15:0]});
	endfunction
	function automatic logic [15:0] remap(logic [15:0] x);
		logic [15:0] y;
		for (int k = 0; k < 16; k++)
			y[k] = x[(k % 2) ? sel[k / 2][7:4] : sel[k / 2][3:0]];
		return y;
	endfunction
	function automatic logic [15:0] avg(logic [15:0] x, logic [15:0] y);
		logic [16:0] s;
		s = {x[15], x} + {y[15], y};
		return s[16:1];
	endfunction
	task automatic drain();
		logic [31:0] g, e;
		for (int i = 0; i < 3000 && rx_q.size() < exp_q.size(); i++)
			cyc(1);
		`CHK(rx_q.size(), exp_q.size())
		while (rx_q.size() > 0 && exp_q.size() > 0) begin
			g = rx_q.pop_front();
			e = exp_q.pop_front();
			`CHK(g, e)
		end
		rx_q.delete();
		exp_q.delete();
	endtask
	task automatic end_sim();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(60000);
		n_fail++;
		end_sim();
	end

	initial begin
		logic [31:0] a, b;
		bit w, o;
		int k;
		void'($urandom(46276));
		cyc(5);
		rst <= 1'b0;
		cyc(5);
		// reset values, last address is unmapped
		foreach (adr[j]) begin
			spi(1'b1, adr[j], 8'h00);
			`CHK(rd, AFMX_REG_RESET)
			`CHK(rd_oe, 1'b1)
		end
		wr(AFMX_ADDR_PAT_STEP, 8'ha5);
		`CHK(rd_oe, 1'b0)
		spi(1'b1, AFMX_ADDR_PAT_STEP, 8'h00);
		`CHK(rd, 8'ha5)
		// format and width on the 32-bit decimated path, default first
		wr(AFMX_ADDR_DDC_COUNT, 8'h01);
		for (int m = 0; m < 4; m++) begin
			w = m[1];
			o = m[0];
			if (m > 0)
				wr(AFMX_ADDR_FMT, {6'h0, w, o});
			slow <= (m == 2);
			saw_full = 1'b0;
			for (int i = 0; i < 20; i++) begin
				a = (i < 3) ? corner[i] : $urandom;
				b = (i < 3) ? corner[2 - i] : $urandom;
				push(1'b1, a, b);
				expect_fmt(a, b, w, o);
			end
			idle();
			drain();
			if (m == 2)
				`CHK(saw_full, 1'b1)
		end
		slow <= 1'b0;
		wr(AFMX_ADDR_DDC_COUNT, 8'h00);
		wr(AFMX_ADDR_FMT, 8'h00);
		// ramp, toggle, then ramp on the full clock in decimation; one idle cycle
		// between samples makes the full clock ramp move two steps per sample
		for (int c = 0; c < 3; c++) begin
			wr(AFMX_ADDR_DDC_COUNT, {7'h00, c == 2});
			wr(AFMX_ADDR_PAT_CTRL, (c == 1) ? {4'h0, AFMX_PAT_TOGGLE} : {3'h0, c == 2, AFMX_PAT_RAMP});
			wr(AFMX_ADDR_PAT_STEP, 8'h10);
			for (int i = 0; i < 6; i++) begin
				push(c == 2, 32'h12340000, 32'h56780000);
				idle();
				cyc(1);
			end
			cyc(40);
			`CHK(rx_q.size(), 6)
			for (int i = 0; i + 1 < rx_q.size(); i++) begin
				`CHK(rx_q[i][31:16], rx_q[i][15:0])
				`CHK(rx_q[i+1][31:16], (c == 1) ? ~rx_q[i][31:16] : rx_q[i][31:16] + 16'(c / 2 + 1))
			end
			rx_q.delete();
		end
		wr(AFMX_ADDR_PAT_CTRL, 8'h00);
		wr(AFMX_ADDR_DDC_COUNT, 8'h00);
		// lane remap with a forced duplicate, then remap off
		for (int j = 0; j < 8; j++) begin
			sel[j] = (j == 7) ? 8'h00 : 8'($urandom);
			wr(AFMX_ADDR_LANE_SEL0 + 12'(j), sel[j]);
		end
		for (int en = 0; en < 2; en++) begin
			wr(AFMX_ADDR_LANE_CTRL, en ? 8'h00 : 8'h80);
			for (int i = 0; i < 4; i++) begin
				a = $urandom;
				b = $urandom;
				push(1'b0, a, b);
				exp_q.push_back(en ? {a[31:16], b[31:16]} : {remap(a[31:16]), remap(b[31:16])});
			end
			idle();
			drain();
		end
		wr(AFMX_ADDR_LANE_CTRL, 8'h00);
		// averaged channel a, channel b straight through
		wr(AFMX_ADDR_FMT, 8'h04);
		wr(AFMX_ADDR_DDC0_SEL, AFMX_DDC0_AVG);
		wr(AFMX_ADDR_DDC_COUNT, 8'h20);
		for (int i = 0; i < 8; i++) begin
			a = (i < 3) ? corner[i] : $urandom;
			b = (i < 3) ? corner[(i + 1) % 3] : $urandom;
			push(1'b0, a, b);
			exp_q.push_back({avg(a[31:16], b[31:16]), b[31:16]});
		end
		idle();
		drain();
		wr(AFMX_ADDR_DDC0_SEL, 8'h00);
		wr(AFMX_ADDR_FMT, 8'h00);
		wr(AFMX_ADDR_DDC_COUNT, 8'h00);
		// low latency with the pattern requested: raw sample after nine edges
		wr(AFMX_ADDR_PAT_CTRL, 8'h02);
		wr(AFMX_ADDR_LAT_CTRL, 8'h10);
		cyc(5);
		a = $urandom;
		b = $urandom;
		channel_a_sample <= a[15:0];
		channel_b_sample <= b[15:0];
		sv <= 1'b1;
		cyc(1);
		sv <= 1'b0;
		// the edge that takes the sample is the first of the nine
		k = 1;
		do begin
			cyc(1);
			#1;
			k++;
		end while (ovld !== 1'b1 && k < 20);
		`CHK(k, 9)
		`CHK({rise, fall}, {a[15:0], b[15:0]})
		wr(AFMX_ADDR_LAT_CTRL, 8'h00);
		wr(AFMX_ADDR_PAT_CTRL, 8'h00);
		rx_q.delete();
		// power down by register, frozen without the sampling clock
		wr(AFMX_ADDR_PDN, 8'h10);
		cyc(6);
		`CHK(pd, 1'b1)
		cp <= 1'b0;
		cyc(4);
		wr(AFMX_ADDR_PDN, 8'h00);
		`CHK(pd, 1'b1)
		cp <= 1'b1;
		cyc(6);
		`CHK(pd, 1'b0)
		foreach (codes[j]) begin
			wr(AFMX_ADDR_PIN_FUNC, {3'h0, codes[j]});
			aux1 <= 1'b1;
			cyc(6);
			`CHK(pd, codes[j] == AFMX_PIN_PDN_AUX1)
			aux1 <= 1'b0;
			aux0 <= 1'b1;
			cyc(6);
			`CHK(pd, codes[j] != AFMX_PIN_PDN_AUX1)
			aux0 <= 1'b0;
			cyc(6);
		end
		end_sim();
	end
endmodule
